// file: hdl/rcd_map.svh
// What this block does
// - Set command ignored on standard-mode channels
// - Illegal channel number raises command error flag
// - Intervals count two millisecond units
// - Zero active gives zero duty; never full
// - Zero inactive interval stored as one
// - New intervals apply after current phase ends
// - Get command opcode 0x06, channel 0..15
// - Get reply: active then inactive interval
// - Reply meaningful only for PWM-mode channels
// - Reply shows latest set values or defaults
// - Set command opcode 0x05, no response
// - Mode bit one selects PWM; reset defaults
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH

// ======================================================
// Command codes and limits
`define RCD_OP_SET      8'h05
`define RCD_OP_GET      8'h06
`define RCD_MAX_CH      8'h0f
`define RCD_DEF_ON      8'h00
`define RCD_DEF_OFF     8'h01
`define RCD_MIN_OFF     8'h01

// ======================================================
// Register byte offsets
`define RCD_OFF_CMD     12'h000
`define RCD_OFF_REPLY   12'h004
`define RCD_OFF_MODE    12'h008
`define RCD_OFF_STATUS  12'h00c
`define RCD_OFF_MASK    12'h010
`define RCD_OFF_OUT     12'h014

// ======================================================
// Status bits and timing
`define RCD_ST_ERR      0
`define RCD_ST_RPL      1
`define RCD_TICK_MS     2
`define RCD_CLK_KHZ     200000

`endif

// file: hdl/rcd_pkg.sv
package rcd_pkg;

    // ======================================================
    // Command word as written by software
    typedef struct packed {
        logic [7:0] inactive_interval;
        logic [7:0] active_interval;
        logic [7:0] channel;
        logic [7:0] opcode;
    } rcd_cmd_t;

    // Reply word of a get-duty command
    typedef struct packed {
        logic [14:0] pad;
        logic        valid;
        logic [7:0]  inactive_interval;
        logic [7:0]  active_interval;
    } rcd_reply_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ON   = 2'b01,
        PH_OFF  = 2'b10
    } rcd_phase_t;

endpackage : rcd_pkg

// file: hdl/rcd_top.sv
// The APB interface to the registers and the address map were left to the implementer.
`include "rcd_map.svh"

module rcd_top
    import rcd_pkg::*;
#(
    parameter int NCH        = 16,
    parameter int TICK_CYCLES = `RCD_TICK_MS * `RCD_CLK_KHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic [NCH-1:0]   chan_out
);

    // ======================================================
    // State
    logic [31:0]      prdata_reg,  prdata_next;
    logic             pready_reg,  pready_next;
    logic             pslverr_reg, pslverr_next;
    logic             irq_reg,     irq_next;
    logic [NCH-1:0]   out_reg,     out_next;
    logic [NCH-1:0]   mode_reg,    mode_next;
    logic [1:0]       status_reg,  status_next;
    logic [1:0]       mask_reg,    mask_next;
    rcd_reply_t       reply_reg,   reply_next;
    logic [31:0]      tick_reg,    tick_next;
    logic [7:0]       act_reg   [NCH];
    logic [7:0]       act_next  [NCH];
    logic [7:0]       inact_reg [NCH];
    logic [7:0]       inact_next[NCH];
    logic [7:0]       cnt_reg   [NCH];
    logic [7:0]       cnt_next  [NCH];
    rcd_phase_t       ph_reg    [NCH];
    rcd_phase_t       ph_next   [NCH];

    logic             access;
    logic             done;
    logic             tick;
    logic             mapped;
    rcd_cmd_t         cmd;
    logic             cmd_wr;
    logic             set_cmd;
    logic             get_cmd;
    logic             ch_ok;
    logic [3:0]       ch;
    logic [1:0]       events;

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign irq      = irq_reg;
    assign chan_out = out_reg;

    // Legal channel numbers run 0..NCH-1
    function automatic logic chan_legal(input logic [7:0] c);
        return c <= `RCD_MAX_CH;
    endfunction : chan_legal

    function automatic logic addr_hit(input logic [11:0] a);
        return a == `RCD_OFF_CMD    || a == `RCD_OFF_REPLY ||
               a == `RCD_OFF_MODE   || a == `RCD_OFF_STATUS ||
               a == `RCD_OFF_MASK   || a == `RCD_OFF_OUT;
    endfunction : addr_hit

    // ======================================================
    // Bus decode: one wait state, effect at the completing edge
    always_comb begin
        access  = psel && penable;
        done    = access && pready_reg;
        mapped  = addr_hit(paddr);
        cmd     = rcd_cmd_t'(pwdata);
        cmd_wr  = done && pwrite && paddr == `RCD_OFF_CMD;
        ch_ok   = chan_legal(cmd.channel);
        ch      = cmd.channel[3:0];
        set_cmd = cmd_wr && cmd.opcode == `RCD_OP_SET;
        get_cmd = cmd_wr && cmd.opcode == `RCD_OP_GET;
        tick    = tick_reg == 32'h0;
    end

    // ======================================================
    // Next values of the whole block
    always_comb begin
        pready_next  = access && !pready_reg;
        pslverr_next = access && !pready_reg && !mapped;
        prdata_next  = prdata_reg;
        mode_next    = mode_reg;
        mask_next    = mask_reg;
        reply_next   = reply_reg;
        events       = 2'b00;
        // Tick counter reloads so the period is exactly TICK_CYCLES
        tick_next    = tick ? 32'(TICK_CYCLES - 1)
                            : tick_reg - 32'h1;

        // Read data is prepared in the first access cycle
        if (access && !pready_reg && !pwrite) begin
            unique case (paddr)
                `RCD_OFF_REPLY:  prdata_next = reply_reg;
                `RCD_OFF_MODE:   prdata_next = 32'(mode_reg);
                `RCD_OFF_STATUS: prdata_next = 32'(status_reg);
                `RCD_OFF_MASK:   prdata_next = 32'(mask_reg);
                `RCD_OFF_OUT:    prdata_next = 32'(out_reg);
                default:         prdata_next = 32'h0;
            endcase
        end

        if (done && pwrite && paddr == `RCD_OFF_MODE)
            mode_next = pwdata[NCH-1:0];
        if (done && pwrite && paddr == `RCD_OFF_MASK)
            mask_next = pwdata[1:0];

        // Unknown opcodes are treated as command errors too
        if (cmd_wr && (!ch_ok || !(set_cmd || get_cmd)))
            events[`RCD_ST_ERR] = 1'b1;
        if (get_cmd && ch_ok) begin
            reply_next.pad               = 15'h0;
            reply_next.active_interval   = act_reg[ch];
            reply_next.inactive_interval = inact_reg[ch];
            reply_next.valid             = mode_reg[ch];
            events[`RCD_ST_RPL]          = 1'b1;
        end

        // Read clears status, but a new event wins over the clear
        if (done && !pwrite && paddr == `RCD_OFF_STATUS)
            status_next = events;
        else
            status_next = status_reg | events;
        irq_next = |(status_next & mask_next);

        for (int i = 0; i < NCH; i++) begin
            act_next[i]   = act_reg[i];
            inact_next[i] = inact_reg[i];
            cnt_next[i]   = cnt_reg[i];
            ph_next[i]    = ph_reg[i];
            if (!mode_reg[i]) begin
                // Entering PWM starts from the default intervals
                act_next[i]   = `RCD_DEF_ON;
                inact_next[i] = `RCD_DEF_OFF;
                cnt_next[i]   = 8'h0;
                ph_next[i]    = PH_IDLE;
            end else begin
                if (set_cmd && ch_ok && 4'(i) == ch) begin
                    act_next[i]   = cmd.active_interval;
                    inact_next[i] = cmd.inactive_interval == 8'h0
                                    ? `RCD_MIN_OFF
                                    : cmd.inactive_interval;
                end
                // Reload uses stored intervals only at phase end
                if (tick) begin
                    if (cnt_reg[i] > 8'h1) begin
                        cnt_next[i] = cnt_reg[i] - 8'h1;
                    end else begin
                        unique case (ph_reg[i])
                            PH_ON: begin
                                ph_next[i]  = PH_OFF;
                                cnt_next[i] = inact_reg[i];
                            end
                            PH_IDLE, PH_OFF: begin
                                // Zero active never asserts output
                                if (act_reg[i] == 8'h0) begin
                                    ph_next[i]  = PH_OFF;
                                    cnt_next[i] = inact_reg[i];
                                end else begin
                                    ph_next[i]  = PH_ON;
                                    cnt_next[i] = act_reg[i];
                                end
                            end
                            default: begin
                                ph_next[i]  = PH_IDLE;
                                cnt_next[i] = 8'h0;
                            end
                        endcase
                    end
                end
            end
            out_next[i] = ph_next[i] == PH_ON;
        end
    end

    // ======================================================
    // Registers; ce low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
            out_reg     <= '0;
            mode_reg    <= '0;
            status_reg  <= 2'b00;
            mask_reg    <= 2'b00;
            reply_reg   <= '0;
            tick_reg    <= 32'(TICK_CYCLES - 1);
            for (int i = 0; i < NCH; i++) begin
                act_reg[i]   <= `RCD_DEF_ON;
                inact_reg[i] <= `RCD_DEF_OFF;
                cnt_reg[i]   <= 8'h0;
                ph_reg[i]    <= PH_IDLE;
            end
        end else if (ce) begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
            out_reg     <= out_next;
            mode_reg    <= mode_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            reply_reg   <= reply_next;
            tick_reg    <= tick_next;
            for (int i = 0; i < NCH; i++) begin
                act_reg[i]   <= act_next[i];
                inact_reg[i] <= inact_next[i];
                cnt_reg[i]   <= cnt_next[i];
                ph_reg[i]    <= ph_next[i];
            end
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence first_access_s;
        psel && penable && !pready_reg && ce;
    endsequence

    sequence set_std_s;
        ce && set_cmd && ch_ok && !mode_reg[ch];
    endsequence

    apb_wait_one_a: assert property (
        first_access_s |=> pready_reg)
        else $error("pready not raised after one wait");

    set_standard_a: assert property (
        set_std_s ##1 1'b1 |-> act_reg[$past(ch)] == `RCD_DEF_ON)
        else $error("set changed a standard channel");

    cmd_error_a: assert property (
        ce && cmd_wr && !ch_ok |=> status_reg[`RCD_ST_ERR])
        else $error("illegal channel did not flag error");

    tick_reload_a: assert property (
        ce && tick |=> tick_reg == 32'(TICK_CYCLES - 1))
        else $error("tick period wrong");

    zero_duty_a: assert property (
        $rose(out_reg[1]) |-> $past(act_reg[1]) != 8'h0)
        else $error("output asserted with zero active");

    off_min_a: assert property (
        inact_reg[1] != 8'h0)
        else $error("inactive interval zero stored");

    hold_phase_a: assert property (
        // Mode writes may drop an output off a tick; leave them out
        !(ce && tick) && $stable(mode_reg) |=> $stable(out_reg))
        else $error("output moved off a tick");

    get_reply_a: assert property (
        ce && get_cmd && ch_ok |=>
            reply_reg.active_interval == $past(act_reg[ch]) &&
            reply_reg.inactive_interval == $past(inact_reg[ch]))
        else $error("get reply mismatch");

    mode_default_a: assert property (
        ce && $rose(mode_reg[0]) |->
            act_reg[0] == `RCD_DEF_ON && inact_reg[0] == `RCD_DEF_OFF)
        else $error("defaults missing on PWM entry");

    irq_level_a: assert property (
        ce |=> irq_reg == |(status_reg & mask_reg))
        else $error("irq does not follow masked status");

    // Set command accepted on a PWM channel
    sequence set_pwm_s;
        ce && set_cmd && ch_ok && mode_reg[ch];
    endsequence

    set_store_a: assert property (
        set_pwm_s |=> act_reg[$past(ch)] == $past(cmd.active_interval))
        else $error("set did not store active interval");

    zero_off_a: assert property (
        set_pwm_s ##0 cmd.inactive_interval == 8'h0 |=>
            inact_reg[$past(ch)] == `RCD_MIN_OFF)
        else $error("zero inactive interval not stored as one");

    reply_valid_a: assert property (
        ce && get_cmd && ch_ok |=> reply_reg.valid == $past(mode_reg[ch]))
        else $error("reply valid does not follow mode");

    // Mid-phase ticks only count down; reload is checked elsewhere
    count_step_a: assert property (
        ce && tick && mode_reg[1] && cnt_reg[1] > 8'h1 |=>
            cnt_reg[1] == $past(cnt_reg[1]) - 8'h1)
        else $error("phase counter did not step by one");

endmodule : rcd_top

// file: tb/rcd_host.sv
// =============================================
// Host side: APB master issuing command words
module rcd_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // One transfer; request held until pready is seen at an edge
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : rcd_host

// file: tb/rcd_bench.sv
// =============================================
// Bench top with interval model per channel
module rcd_bench;
    import rcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TK = 20;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready;
    logic        pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] chan_out;
    logic        e;
    int          n_errors, checks, cyc, t0, t1, act[16], inact[16];
    logic [15:0] mode;

    rcd_top #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .chan_out(chan_out));
    rcd_host host (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // 200 MHz clock and a cycle count for phase lengths
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    task summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Commands go through the model so expectations track the rules
    task set(input int ch, input int a, input int i);
        host.xfer(1'b1, 12'h000, {i[7:0], a[7:0], ch[7:0], 8'h05}, r, e);
        if (ch < 16 && mode[ch]) begin
            act[ch] = a;
            inact[ch] = (i == 0) ? 1 : i;
        end
    endtask : set

    task get(input int ch);
        host.xfer(1'b1, 12'h000, {16'h0, ch[7:0], 8'h06}, r, e);
        host.xfer(1'b0, 12'h004, 32'h0, r, e);
        chk("reply", {15'h0, mode[ch], inact[ch][7:0], act[ch][7:0]}, r);
    endtask : get

    // Time of the next level change of one channel; channel 2 never on
    task edge_at(input int ch, input logic lvl, output int t);
        int k;
        k = 0;
        while (chan_out[ch] !== lvl && k < 400) begin
            @(negedge pclk);
            k++;
            if (chan_out[2] !== 1'b0) chk("ch2", 0, 1);
        end
        if (k >= 400) chk("edge", 32'(lvl), 32'(chan_out[ch]));
        t = cyc;
    endtask : edge_at

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        summarize();
    end

    // =============================================
    // Main sequence
    initial begin
        int ch, iv;
        presetn = 1'b0;
        ce = 1'b1;
        mode = 16'h0;
        for (int c = 0; c < 16; c++) begin
            act[c] = 0;
            inact[c] = 1;
        end
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'h6d07341e));
        host.xfer(1'b0, 12'h008, 32'h0, r, e);
        chk("mode", 0, r);
        set(5, 7, 9);
        get(5);
        host.xfer(1'b1, 12'h008, 32'hffff, r, e);
        mode = 16'hffff;
        for (int k = 0; k < 8; k++) begin
            ch = $urandom_range(15, 8);
            iv = (k == 0) ? 0 : $urandom_range(255);
            set(ch, $urandom_range(255), iv);
            get(ch);
        end
        // Bad channel, bad opcode: error flag, irq, read clears
        host.xfer(1'b1, 12'h010, 32'h1, r, e);
        host.xfer(1'b0, 12'h010, 32'h0, r, e);
        chk("mask", 1, r);
        for (int k = 0; k < 3; k++) begin
            host.xfer(1'b1, 12'h000, (k == 2) ? 32'h0107 : 32'h1005 + k, r, e);
            @(negedge pclk);
            chk("irq", 1, irq);
            host.xfer(1'b0, 12'h00c, 32'h0, r, e);
            chk("err", 1, r & 32'h1);
            @(negedge pclk);
            chk("irq", 0, irq);
        end
        host.xfer(1'b0, 12'h018, 32'h0, r, e);
        chk("slverr", 1, e);
        chk("rdata", 0, r);
        // Phase lengths, then a change in the middle of an on phase
        set(1, 2, 3);
        edge_at(1, 1'b1, t0);
        edge_at(1, 1'b0, t1);
        chk("on", 2 * TK, t1 - t0);
        edge_at(1, 1'b1, t0);
        chk("off", 3 * TK, t0 - t1);
        set(1, 4, 0);
        edge_at(1, 1'b0, t1);
        chk("old on", 2 * TK, t1 - t0);
        edge_at(1, 1'b1, t0);
        chk("new off", TK, t0 - t1);
        edge_at(1, 1'b0, t1);
        chk("new on", 4 * TK, t1 - t0);
        get(1);
        get(2);
        summarize();
    end
endmodule : rcd_bench
